// ===== design/adcc_pkg.sv
// package: register map, field positions, reset values and timing for the converter control
package adcc_pkg;
    localparam logic [7:0] RESULT_ADDR = 8'hD0;
    localparam logic [7:0] CTRL_ADDR = 8'hD1;
    localparam logic [7:0] CTRL_RESET = 8'h40;
    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam int IRQ_EN_BIT = 7;
    localparam int EOC_BIT = 6;
    localparam int START_BIT = 5;
    localparam int POWER_BIT = 4;
    localparam int OSC_OFF_BIT = 2;
    // cycles spent on each approximation step (settle then compare)
    localparam logic [3:0] STEP_CYCLES = 4'h8;
    localparam logic [3:0] STEP_LAST = STEP_CYCLES - 4'h1;
    localparam logic [2:0] BIT_MSB = 3'h7;
    localparam logic [2:0] BIT_LSB = 3'h0;
    typedef enum logic [1:0] {
        ADCC_IDLE,
        ADCC_STEP,
        ADCC_DONE
    } adcc_state_t;
endpackage

// ===== design/adcc_sar.sv
// successive-approximation sequencer: eight steps, msb first
module adcc_sar (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic start_i,
    input wire logic run_i,
    input wire logic cmp_high_i,
    output logic [7:0] trial_o,
    output logic busy_o,
    output logic done_o,
    output logic [7:0] result_o
);
    adcc_pkg::adcc_state_t state_reg, state_next;
    logic [7:0] trial_reg, trial_next;
    logic [2:0] bit_reg, bit_next;
    logic [3:0] cnt_reg, cnt_next;
    logic done_reg, done_next;
    logic [7:0] bitmask;

    assign bitmask = 8'h01 << bit_reg;
    assign trial_o = trial_reg;
    assign busy_o = (state_reg == adcc_pkg::ADCC_STEP);
    assign done_o = done_reg;
    assign result_o = trial_reg;

    always_comb begin
        state_next = state_reg;
        trial_next = trial_reg;
        bit_next = bit_reg;
        cnt_next = cnt_reg;
        done_next = 1'b0;
        if (!run_i) begin
            state_next = adcc_pkg::ADCC_IDLE;
        end else if (start_i) begin
            // a new start abandons any running conversion
            state_next = adcc_pkg::ADCC_STEP;
            bit_next = adcc_pkg::BIT_MSB;
            trial_next = 8'h80;
            cnt_next = 4'h0;
        end else begin
            unique case (state_reg)
                adcc_pkg::ADCC_IDLE: begin
                end
                adcc_pkg::ADCC_STEP: begin
                    if (cnt_reg == adcc_pkg::STEP_LAST) begin
                        cnt_next = 4'h0;
                        // input below trial drops the bit; clamps at 00h / FFh naturally
                        if (!cmp_high_i) begin
                            trial_next = trial_reg & ~bitmask;
                        end
                        if (bit_reg == adcc_pkg::BIT_LSB) begin
                            state_next = adcc_pkg::ADCC_DONE;
                        end else begin
                            bit_next = bit_reg - 3'h1;
                            trial_next[bit_reg - 3'h1] = 1'b1;
                        end
                    end else begin
                        cnt_next = cnt_reg + 4'h1;
                    end
                end
                adcc_pkg::ADCC_DONE: begin
                    done_next = 1'b1;
                    state_next = adcc_pkg::ADCC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_reg <= adcc_pkg::ADCC_IDLE;
            trial_reg <= 8'h00;
            bit_reg <= 3'h0;
            cnt_reg <= 4'h0;
            done_reg <= 1'b0;
        end else if (ce_i) begin
            state_reg <= state_next;
            trial_reg <= trial_next;
            bit_reg <= bit_next;
            cnt_reg <= cnt_next;
            done_reg <= done_next;
        end
    end
endmodule

// ===== design/adcc_top.sv
// converter control/status and result registers on the data space bus
module adcc_top (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic wait_mode_i,
    input wire logic stop_mode_i,
    input wire logic cmp_high_i,
    output logic [7:0] rdata_o,
    output logic irq_o,
    output logic wake_o,
    output logic main_osc_disable_o,
    output logic converter_power_on_o,
    output logic [7:0] trial_o,
    output logic sample_o
);
    logic conv_irq_enable_reg, conv_irq_enable_next;
    logic eoc_reg, eoc_next;
    logic converter_power_on_reg, converter_power_on_next;
    logic main_osc_disable_reg, main_osc_disable_next;
    logic [7:0] result_reg, result_next;
    logic [7:0] rdata_reg, rdata_next;
    logic irq_reg, irq_next;
    logic wake_reg, wake_next;
    logic pwr_reg, pwr_next;
    logic sample_reg, sample_next;
    logic [7:0] trial_reg;
    logic cmp_meta_reg, cmp_sync_reg;
    logic ctrl_wr, start_req, run, sar_done, sar_busy;
    logic [7:0] sar_trial, sar_result, ctrl_view;

    assign ctrl_wr = wr_i && (addr_i == adcc_pkg::CTRL_ADDR);
    assign start_req = ctrl_wr && wdata_i[adcc_pkg::START_BIT];
    // stop mode halts the converter; wait mode does not touch it
    assign run = converter_power_on_reg && !stop_mode_i;

    adcc_sar u_sar (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .start_i(start_req),
        .run_i(run),
        .cmp_high_i(cmp_sync_reg),
        .trial_o(sar_trial),
        .busy_o(sar_busy),
        .done_o(sar_done),
        .result_o(sar_result)
    );

    always_comb begin
        ctrl_view = 8'h00;
        ctrl_view[adcc_pkg::IRQ_EN_BIT] = conv_irq_enable_reg;
        ctrl_view[adcc_pkg::EOC_BIT] = eoc_reg;
        ctrl_view[adcc_pkg::START_BIT] = 1'b0;
        ctrl_view[adcc_pkg::POWER_BIT] = converter_power_on_reg;
        ctrl_view[adcc_pkg::OSC_OFF_BIT] = main_osc_disable_reg;
    end

    always_comb begin
        conv_irq_enable_next = conv_irq_enable_reg;
        converter_power_on_next = converter_power_on_reg;
        main_osc_disable_next = main_osc_disable_reg;
        eoc_next = eoc_reg;
        result_next = result_reg;
        if (ctrl_wr) begin
            conv_irq_enable_next = wdata_i[adcc_pkg::IRQ_EN_BIT];
            converter_power_on_next = wdata_i[adcc_pkg::POWER_BIT];
            main_osc_disable_next = wdata_i[adcc_pkg::OSC_OFF_BIT];
        end
        // bit 6 write data ignored; only a start clears the flag
        if (start_req) begin
            eoc_next = 1'b0;
        end else if (sar_done) begin
            eoc_next = 1'b1;
            result_next = sar_result;
        end
        rdata_next = rdata_reg;
        if (rd_i) begin
            unique case (addr_i)
                adcc_pkg::RESULT_ADDR: rdata_next = result_reg;
                adcc_pkg::CTRL_ADDR: rdata_next = ctrl_view;
                default: rdata_next = 8'h00;
            endcase
        end
        irq_next = eoc_next && conv_irq_enable_next;
        // only wait mode wakes on the interrupt; stop mode stays asleep
        wake_next = irq_next && wait_mode_i && !stop_mode_i;
        pwr_next = run;
        sample_next = sar_busy && run;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cmp_meta_reg <= 1'b0;
            cmp_sync_reg <= 1'b0;
        end else if (ce_i) begin
            cmp_meta_reg <= cmp_high_i;
            cmp_sync_reg <= cmp_meta_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            conv_irq_enable_reg <= adcc_pkg::CTRL_RESET[adcc_pkg::IRQ_EN_BIT];
            eoc_reg <= adcc_pkg::CTRL_RESET[adcc_pkg::EOC_BIT];
            converter_power_on_reg <= adcc_pkg::CTRL_RESET[adcc_pkg::POWER_BIT];
            main_osc_disable_reg <= adcc_pkg::CTRL_RESET[adcc_pkg::OSC_OFF_BIT];
            result_reg <= adcc_pkg::RESULT_RESET;
            rdata_reg <= 8'h00;
            irq_reg <= 1'b0;
            wake_reg <= 1'b0;
            pwr_reg <= 1'b0;
            sample_reg <= 1'b0;
            trial_reg <= 8'h00;
        end else if (ce_i) begin
            conv_irq_enable_reg <= conv_irq_enable_next;
            eoc_reg <= eoc_next;
            converter_power_on_reg <= converter_power_on_next;
            main_osc_disable_reg <= main_osc_disable_next;
            result_reg <= result_next;
            rdata_reg <= rdata_next;
            irq_reg <= irq_next;
            wake_reg <= wake_next;
            pwr_reg <= pwr_next;
            sample_reg <= sample_next;
            trial_reg <= sar_trial;
        end
    end

    assign rdata_o = rdata_reg;
    assign irq_o = irq_reg;
    assign wake_o = wake_reg;
    assign main_osc_disable_o = main_osc_disable_reg;
    assign converter_power_on_o = pwr_reg;
    assign trial_o = trial_reg;
    assign sample_o = sample_reg;
endmodule

// ===== tb/adcc_top_asserts.sv
// checker: port-level properties of the converter control block
module adcc_top_asserts (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic wait_mode_i,
    input wire logic stop_mode_i,
    input wire logic [7:0] rdata_o,
    input wire logic irq_o,
    input wire logic wake_o,
    input wire logic main_osc_disable_o,
    input wire logic converter_power_on_o,
    input wire logic sample_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] run_cnt_reg;
    logic [7:0] run_cnt_next;
    logic ctl_wr;
    logic start_wr;
    logic rd_tk;
    assign ctl_wr = ce_i && wr_i && addr_i == adcc_pkg::CTRL_ADDR;
    assign start_wr = ctl_wr && wdata_i[adcc_pkg::START_BIT];
    assign rd_tk = ce_i && rd_i;
    always_comb begin
        run_cnt_next = (sample_o && !start_wr) ? run_cnt_reg + 8'h01 : 8'h00;
    end
    always_ff @(posedge clk_i) begin
        run_cnt_reg <= rst_n_i ? run_cnt_next : 8'h00;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_unmapped; rd_tk && addr_i[7:1] != 7'h68 |=> rdata_o == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_ctl_rd; rd_tk && addr_i == adcc_pkg::CTRL_ADDR |=> (rdata_o & 8'h2B) == 8'h00
        && rdata_o[2] == $past(main_osc_disable_o); endproperty
    a_ctl_rd: assert property (p_ctl_rd) else $error("control readback wrong");
    property p_osc_wr; ctl_wr |=> main_osc_disable_o == $past(wdata_i[2]); endproperty
    a_osc_wr: assert property (p_osc_wr) else $error("osc disable not written");
    property p_rd_hold; !rd_tk |=> $stable(rdata_o); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_stop_pwr; stop_mode_i |=> !converter_power_on_o; endproperty
    a_stop_pwr: assert property (p_stop_pwr) else $error("power on in stop");
    property p_stop_wake; stop_mode_i |=> !wake_o; endproperty
    a_stop_wake: assert property (p_stop_wake) else $error("wake from stop");
    property p_wake_wait; wake_o |-> $past(wait_mode_i); endproperty
    a_wake_wait: assert property (p_wake_wait) else $error("wake outside wait");
    property p_start_clr; start_wr |=> ##1 !irq_o; endproperty
    a_start_clr: assert property (p_start_clr) else $error("irq kept after start");
    property p_conv_len; run_cnt_reg <= 8'h48; endproperty
    a_conv_len: assert property (p_conv_len) else $error("conversion too long");
    property p_sample_rise; $rose(sample_o) |-> $past(start_wr, 2); endproperty
    a_sample_rise: assert property (p_sample_rise) else $error("start without write");
endmodule

bind adcc_top adcc_top_asserts i_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .wait_mode_i(wait_mode_i),
    .stop_mode_i(stop_mode_i), .rdata_o(rdata_o), .irq_o(irq_o), .wake_o(wake_o),
    .main_osc_disable_o(main_osc_disable_o), .converter_power_on_o(converter_power_on_o),
    .sample_o(sample_o));

// ===== tb/adcc_top_tb.sv
// testbench: register access and conversion checks for the converter control
module adcc_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic ce_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic wait_mode_i = 1'b0;
    logic stop_mode_i = 1'b0;
    logic cmp_high_i = 1'b0;
    logic [7:0] rdata_o, trial_o, rv;
    logic [7:0] m_ctl = 8'h40;
    logic irq_o, wake_o, osc_o, pwr_o, sample_o;
    int error_cnt = 0;
    int checks = 0;
    int seed = 32'h28D9;
    int ain = 0;
    int q[$];
    adcc_top i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .wait_mode_i(wait_mode_i),
        .stop_mode_i(stop_mode_i), .cmp_high_i(cmp_high_i), .rdata_o(rdata_o), .irq_o(irq_o),
        .wake_o(wake_o), .main_osc_disable_o(osc_o), .converter_power_on_o(pwr_o),
        .trial_o(trial_o), .sample_o(sample_o));
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        #1 cmp_high_i = ain >= int'(trial_o);
    end
    task automatic stop_test;
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i) #1 wr_i = w;
        rd_i = !w;
        addr_i = a;
        wdata_i = d;
        @(posedge clk_i) #1 wr_i = 1'b0;
        rd_i = 1'b0;
        rv = rdata_o;
    endtask
    task automatic wctl(input logic [7:0] d);
        bus(1'b1, adcc_pkg::CTRL_ADDR, d & 8'hF4);
        if (d[5] && d[4] && m_ctl[4] && !stop_mode_i) q = {ain};
        m_ctl = {d[7], d[5] ? 1'b0 : m_ctl[6], 1'b0, d[4], 1'b0, d[2], 2'b00};
    endtask
    task automatic done_wait;
        int n = 0;
        while (irq_o !== 1'b1 && n < 200) begin
            @(posedge clk_i) #1 n++;
        end
        m_ctl[6] = 1'b1;
        chk("irq", 8'h01, {7'h00, irq_o});
        bus(1'b0, adcc_pkg::RESULT_ADDR, 8'h00);
        chk("result", 8'(q.pop_front()), rv);
        bus(1'b0, adcc_pkg::CTRL_ADDR, 8'h00);
        chk("ctl_done", m_ctl, rv);
    endtask
    initial begin
        #200000 error_cnt++;
        stop_test();
    end
    initial begin
        repeat (16) @(posedge clk_i);
        #1 rst_n_i = 1'b1;
        bus(1'b0, adcc_pkg::CTRL_ADDR, 8'h00);
        chk("ctl_rst", 8'h40, rv);
        bus(1'b1, adcc_pkg::RESULT_ADDR, 8'hA5);
        bus(1'b0, adcc_pkg::RESULT_ADDR, 8'h00);
        chk("res_ro", adcc_pkg::RESULT_RESET, rv);
        bus(1'b0, 8'h55, 8'h00);
        chk("unmapped", 8'h00, rv);
        wctl(8'h24);
        bus(1'b0, adcc_pkg::CTRL_ADDR, 8'h00);
        chk("ctl_nopwr", m_ctl, rv);
        chk("osc", 8'h01, {7'h00, osc_o});
        ce_i = 1'b0;
        bus(1'b1, adcc_pkg::CTRL_ADDR, 8'h90);
        ce_i = 1'b1;
        bus(1'b0, adcc_pkg::CTRL_ADDR, 8'h00);
        chk("ce_frz", m_ctl, rv);
        wctl(8'h90);
        repeat (2) @(posedge clk_i);
        #1 chk("pwr", 8'h01, {7'h00, pwr_o});
        for (int i = 0; i < 8; i++) begin
            ain = i == 0 ? 255 : i == 1 ? 0 : $random(seed) & 255;
            wctl(8'hB0);
            bus(1'b0, adcc_pkg::CTRL_ADDR, 8'h00);
            chk("eoc_clr", m_ctl, rv);
            chk("trial_msb", 8'h80, trial_o);
            chk("busy", 8'h01, {7'h00, sample_o});
            done_wait();
        end
        wctl(8'h90);
        bus(1'b0, adcc_pkg::CTRL_ADDR, 8'h00);
        chk("eoc_w0", m_ctl, rv);
        wctl(8'h10);
        repeat (2) @(posedge clk_i);
        #1 chk("irq_off", 8'h00, {7'h00, irq_o});
        ain = 8'h3C;
        wctl(8'hB0);
        repeat (30) @(posedge clk_i);
        ain = $random(seed) & 255;
        wctl(8'hB0);
        done_wait();
        wait_mode_i = 1'b1;
        wctl(8'hB0);
        done_wait();
        repeat (2) @(posedge clk_i);
        #1 chk("wake", 8'h01, {7'h00, wake_o});
        stop_mode_i = 1'b1;
        wctl(8'hB0);
        repeat (100) @(posedge clk_i);
        #1 chk("stop_irq", 8'h00, {7'h00, irq_o});
        stop_mode_i = 1'b0;
        wait_mode_i = 1'b0;
        wctl(8'hB0);
        done_wait();
        repeat (150) @(posedge clk_i);
        #1 chk("no_auto", 8'h00, {7'h00, sample_o});
        wctl(8'hB0);
        repeat (10) @(posedge clk_i);
        #1 rst_n_i = 1'b0;
        repeat (2) @(posedge clk_i);
        #1 rst_n_i = 1'b1;
        m_ctl = 8'h40;
        bus(1'b0, adcc_pkg::CTRL_ADDR, 8'h00);
        chk("ctl_rst2", m_ctl, rv);
        chk("pwr_rst", 8'h00, {7'h00, pwr_o});
        chk("busy_rst", 8'h00, {7'h00, sample_o});
        stop_test();
    end
endmodule
